// >>> ncc_pkg.sv
// constants and types shared by both ends of the command control register port
// assumes one clock for host and device, and 8-bit registers on 4 address lines
//
// Contract
// - halt goes off-line after current traffic drains
// - reset done flag shows reset has taken effect
// - power-up: halt high, run low
// - halt while running keeps run reading set
// - run activates core from any reset
// - tx launch starts packet, self-clears on end
// - host launches only after programming transmit registers
// - writing zero to tx launch does nothing
// - host keeps running dma command with launch
// - unreloaded dma reissue completes at once
// - host starts dma with tx launch zero (host end forwards the requested launch bit)
// - host never mixes remote read and write
// - page, abort and halt writable any time
// - top dma bit aborts and marks complete
// - abort leaves remote start address advanced
// - host clears remote byte count after abort
// - host touches data port after early abort
// - page field selects page zero to two
// - eight-bit registers, sixteen per page
// - reset done set on reset, cleared on start
package ncc_pkg;
	localparam int NCC_DW = 8;
	localparam int NCC_AW = 4;
	localparam logic [3:0] CMD_OFS = 4'h0;
	localparam logic [3:0] TPSR_OFS = 4'h4;
	localparam logic [3:0] TBC0_OFS = 4'h5;
	localparam logic [3:0] TBC1_OFS = 4'h6;
	localparam logic [3:0] RBC0_OFS = 4'hA;
	localparam logic [3:0] RBC1_OFS = 4'hB;
	localparam int HALT_B = 0;
	localparam int RUN_B = 1;
	localparam int TX_B = 2;
	localparam int RD_LO = 3;
	localparam int RD_HI = 5;
	localparam int PS_LO = 6;
	localparam int PS_HI = 7;
	localparam logic [2:0] RD_NONE = 3'h0;
	localparam logic [2:0] RD_READ = 3'h1;
	localparam logic [2:0] RD_WRITE = 3'h2;
	localparam logic [2:0] RD_SEND = 3'h3;
	localparam logic [2:0] RD_ABORT = 3'h4;
	localparam logic [1:0] PAGE0 = 2'h0;
	localparam logic [1:0] PAGE1 = 2'h1;
	localparam logic [1:0] PAGE2 = 2'h2;
	localparam logic [1:0] PAGE_RSVD = 2'h3;
	localparam logic HALT_RST = 1'h1;
	localparam logic RUN_RST = 1'h0;
	localparam logic [2:0] RD_RST = 3'h4;
	localparam logic [1:0] PAGE_RST = 2'h0;
	localparam logic [2:0] TXPROG_ALL = 3'h7;
	typedef enum {NCC_OFF, NCC_RUN, NCC_DRAIN} ncc_core_e;
	typedef enum {NCC_H_IDLE, NCC_H_WAIT, NCC_H_CLR, NCC_H_CWAIT} ncc_host_e;
endpackage : ncc_pkg

// >>> ncc_bus_if.sv
// parallel register port between the host and the command control end
// assumes single-cycle strobes and a one-cycle acknowledge from the device
`timescale 1ns/1ps
interface ncc_bus_if;
	logic [3:0] addr;
	logic [7:0] wdata;
	logic [7:0] rdata;
	logic rd;
	logic wr;
	logic ack;
	logic dport_rd;
	logic dport_wr;
	modport dev (input addr, input wdata, input rd, input wr, input dport_rd,
		input dport_wr, output rdata, output ack);
	modport host (output addr, output wdata, output rd, output wr, output dport_rd,
		output dport_wr, input rdata, input ack);
endinterface : ncc_bus_if

// >>> ncc_page_dec.sv
// page and address decode for the register port
// assumes the command register answers at its offset on every page
`timescale 1ns/1ps
module ncc_page_dec
	import ncc_pkg::*;
(
	input wire logic [1:0] page_in,
	input wire logic [3:0] addr_in,
	output logic cmd_hit_out,
	output logic ext_hit_out
);
	assign cmd_hit_out = (addr_in == CMD_OFS);
	assign ext_hit_out = (addr_in != CMD_OFS) && (page_in != PAGE_RSVD);
endmodule : ncc_page_dec

// >>> ncc_dev_end.sv
// device end: command control register and core start/stop sequencing
// assumes transmit reports busy and done, receive reports busy, remote dma reports done and count loaded
`timescale 1ns/1ps
module ncc_dev_end
	import ncc_pkg::*;
(
	ncc_bus_if.dev bus,
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic TX_BUSY_IN,
	input wire logic TX_DONE_IN,
	input wire logic RX_BUSY_IN,
	input wire logic RDMA_DONE_IN,
	input wire logic RBC_LOADED_IN,
	input wire logic [7:0] EXT_RDATA_IN,
	output logic EXT_RD_OUT,
	output logic EXT_WR_OUT,
	output logic [1:0] EXT_PAGE_OUT,
	output logic [3:0] EXT_ADDR_OUT,
	output logic [7:0] EXT_WDATA_OUT,
	output logic ACCEPT_NEW_OUT,
	output logic CORE_OFF_OUT,
	output logic TX_START_OUT,
	output logic RDMA_START_OUT,
	output logic [2:0] RDMA_CMD_OUT,
	output logic RDMA_ABORT_OUT,
	output logic RDMA_CMPL_OUT,
	output logic RESET_DONE_OUT,
	output logic DPORT_RD_OUT,
	output logic DPORT_WR_OUT
);
	ncc_core_e state_r;
	ncc_core_e state_nxt;
	logic halt_r;
	logic halt_nxt;
	logic run_r;
	logic run_nxt;
	logic tx_r;
	logic tx_nxt;
	logic [2:0] rdma_r;
	logic [2:0] rdma_nxt;
	logic rdma_act_r;
	logic rdma_act_nxt;
	logic [1:0] page_r;
	logic [1:0] page_nxt;
	logic rst_flag_r;
	logic rst_flag_nxt;
	logic [7:0] rdata_r;
	logic [7:0] rdata_nxt;
	logic ack_r;
	logic tx_start_r;
	logic rdma_start_r;
	logic rdma_abort_r;
	logic rdma_cmpl_r;
	logic cmd_hit;
	logic ext_hit;

	ncc_page_dec ncc_page_dec_inst (
		.page_in(page_r),
		.addr_in(bus.addr),
		.cmd_hit_out(cmd_hit),
		.ext_hit_out(ext_hit)
	);

	// write decode of the command register
	wire cmd_wr = bus.wr & cmd_hit;
	wire wr_halt = bus.wdata[HALT_B];
	wire wr_run = bus.wdata[RUN_B];
	wire wr_tx = bus.wdata[TX_B];
	wire [2:0] wr_rd = bus.wdata[RD_HI:RD_LO];
	wire [1:0] wr_ps = bus.wdata[PS_HI:PS_LO];
	wire [7:0] cmd_val = {page_r, rdma_r, tx_r, run_r, halt_r};
	wire in_run = (state_r == NCC_RUN);
	wire core_idle = ~TX_BUSY_IN & ~RX_BUSY_IN;

	// start needs halt clear and run set
	wire start_cmd = cmd_wr & ~wr_halt & wr_run;
	// halt taken whatever is in progress
	wire halt_cmd = cmd_wr & wr_halt;
	wire enter_off = (state_r == NCC_DRAIN) & ~start_cmd & core_idle;

	// launch only while running; set beats done
	wire tx_go = cmd_wr & wr_tx & in_run & ~wr_halt & (~tx_r | TX_DONE_IN);

	// top bit aborts, low bits ignored
	wire rd_abort = cmd_wr & wr_rd[2];
	// only read, write and send start a dma
	wire rd_legal = cmd_wr & ~wr_rd[2] & (wr_rd != RD_NONE);
	wire rd_clash = rd_legal & rdma_act_r & (wr_rd != rdma_r);
	// no reloaded count means instant completion
	wire rd_empty = rd_legal & ~rd_clash & ~RBC_LOADED_IN;
	wire rd_begin = rd_legal & ~rdma_act_r & RBC_LOADED_IN;
	wire rd_done = rdma_act_r & RDMA_DONE_IN;
	wire rd_finish = rd_abort | rd_empty | rd_done;

	always_comb begin
		state_nxt = state_r;
		case (state_r)
			// run from power-up or software reset
			NCC_OFF: begin
				if (start_cmd) begin
					state_nxt = NCC_RUN;
				end
			end
			// stop new traffic, let current finish
			NCC_RUN: begin
				if (halt_cmd) begin
					state_nxt = NCC_DRAIN;
				end
			end
			NCC_DRAIN: begin
				if (start_cmd) begin
					state_nxt = NCC_RUN;
				end else if (core_idle) begin
					state_nxt = NCC_OFF;
				end
			end
			default: begin
				state_nxt = NCC_OFF;
			end
		endcase
	end

	assign halt_nxt = cmd_wr ? wr_halt : halt_r;
	// halt after running keeps run reading set
	assign run_nxt = cmd_wr ? (wr_run | (wr_halt & run_r)) : run_r;
	// a zero write never clears launch
	assign tx_nxt = tx_go | (tx_r & ~TX_DONE_IN);
	// no start address restore here on abort
	assign rdma_nxt = rd_abort ? wr_rd :
		(rd_empty | rd_done) ? RD_ABORT :
		rd_begin ? wr_rd : rdma_r;
	assign rdma_act_nxt = rd_begin | (rdma_act_r & ~rd_finish);
	// page field written on every command write
	assign page_nxt = cmd_wr ? wr_ps : page_r;
	// set on entering reset, clear on start
	assign rst_flag_nxt = enter_off | (rst_flag_r & ~start_cmd);
	// byte-wide reads; reserved page reads zero
	assign rdata_nxt = ~bus.rd ? rdata_r :
		cmd_hit ? cmd_val :
		ext_hit ? EXT_RDATA_IN : 8'h00;

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			state_r <= NCC_OFF;
			halt_r <= HALT_RST;
			run_r <= RUN_RST;
			page_r <= PAGE_RST;
		end else begin
			state_r <= state_nxt;
			halt_r <= halt_nxt;
			run_r <= run_nxt;
			page_r <= page_nxt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			tx_r <= 1'b0;
			rdma_r <= RD_RST;
			rdma_act_r <= 1'b0;
		end else begin
			tx_r <= tx_nxt;
			rdma_r <= rdma_nxt;
			rdma_act_r <= rdma_act_nxt;
		end
	end

	// flag raised once reset has taken effect
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			rst_flag_r <= 1'b1;
		end else begin
			rst_flag_r <= rst_flag_nxt;
		end
	end

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			rdata_r <= 8'h00;
			ack_r <= 1'b0;
		end else begin
			rdata_r <= rdata_nxt;
			ack_r <= bus.rd | bus.wr;
		end
	end

	// event pulses are registered so engines see clean one-cycle strobes
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			tx_start_r <= 1'b0;
			rdma_start_r <= 1'b0;
			rdma_abort_r <= 1'b0;
			rdma_cmpl_r <= 1'b0;
		end else begin
			tx_start_r <= tx_go;
			rdma_start_r <= rd_begin;
			rdma_abort_r <= rd_abort & rdma_act_r;
			rdma_cmpl_r <= rd_finish;
		end
	end

	assign bus.rdata = rdata_r;
	assign bus.ack = ack_r;
	// other pages sit outside; their strobes are passed straight through except on the reserved page
	assign EXT_RD_OUT = bus.rd & ext_hit;
	assign EXT_WR_OUT = bus.wr & ext_hit;
	assign EXT_PAGE_OUT = page_r;
	assign EXT_ADDR_OUT = bus.addr;
	assign EXT_WDATA_OUT = bus.wdata;
	assign ACCEPT_NEW_OUT = in_run;
	assign CORE_OFF_OUT = (state_r == NCC_OFF);
	assign TX_START_OUT = tx_start_r;
	assign RDMA_START_OUT = rdma_start_r;
	assign RDMA_CMD_OUT = rdma_r;
	assign RDMA_ABORT_OUT = rdma_abort_r;
	assign RDMA_CMPL_OUT = rdma_cmpl_r;
	assign RESET_DONE_OUT = rst_flag_r;
	assign DPORT_RD_OUT = bus.dport_rd;
	assign DPORT_WR_OUT = bus.dport_wr;
endmodule : ncc_dev_end

// >>> ncc_host_end.sv
// host end: turns user requests into register port strobes
// assumes one request at a time; polices command overlap and abort cleanup
`timescale 1ns/1ps
module ncc_host_end
	import ncc_pkg::*;
(
	ncc_bus_if.host bus,
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic REQ_VALID_IN,
	input wire logic REQ_WRITE_IN,
	input wire logic [3:0] REQ_ADDR_IN,
	input wire logic [7:0] REQ_DATA_IN,
	input wire logic RDMA_DONE_IN,
	output logic REQ_READY_OUT,
	output logic RESP_VALID_OUT,
	output logic [7:0] RESP_DATA_OUT,
	output logic RESP_REFUSED_OUT
);
	ncc_host_e state_r;
	logic [3:0] addr_r;
	logic [7:0] wdata_r;
	logic rd_r;
	logic wr_r;
	logic dport_rd_r;
	logic dport_wr_r;
	logic resp_r;
	logic [7:0] resp_data_r;
	logic refused_r;
	logic [1:0] page_sh_r;
	logic [2:0] rdma_sh_r;
	logic [2:0] txprog_r;
	logic clean_r;
	logic [2:0] clean_kind_r;
	logic step_r;

	wire is_cmd = REQ_WRITE_IN & (REQ_ADDR_IN == CMD_OFS);
	wire [2:0] u_rd = REQ_DATA_IN[RD_HI:RD_LO];
	wire u_tx = REQ_DATA_IN[TX_B];
	wire dma_on = (rdma_sh_r != RD_NONE);
	// launch during dma repeats the running command
	wire keep_rd = is_cmd & u_tx & dma_on & ~u_rd[2];
	wire [2:0] eff_rd = keep_rd ? rdma_sh_r : u_rd;
	wire eff_start = ~eff_rd[2] & (eff_rd != RD_NONE);
	wire eff_abort = is_cmd & eff_rd[2];
	// no remote read over write or the reverse
	wire clash = is_cmd & eff_start & dma_on & (eff_rd != rdma_sh_r);
	// launch refused until all transmit setup writes are seen
	wire tx_unready = is_cmd & u_tx & (txprog_r != TXPROG_ALL);
	wire refuse = clash | tx_unready;
	// abort cleanup works on page 0, so the abort write forces it
	wire [1:0] eff_ps = eff_abort ? PAGE0 : REQ_DATA_IN[PS_HI:PS_LO];
	// dma start wants launch zero; the launch bit here is forwarded as requested
	wire [7:0] eff_data = is_cmd ? {eff_ps, eff_rd, u_tx, REQ_DATA_IN[RUN_B:HALT_B]}
		: REQ_DATA_IN;
	wire p0_wr = REQ_WRITE_IN & (page_sh_r == PAGE0);
	wire [2:0] prog_hit = {p0_wr & (REQ_ADDR_IN == TBC1_OFS),
		p0_wr & (REQ_ADDR_IN == TBC0_OFS), p0_wr & (REQ_ADDR_IN == TPSR_OFS)};
	wire take = (state_r == NCC_H_IDLE) & REQ_VALID_IN;
	wire issue = take & ~refuse;

	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			state_r <= NCC_H_IDLE;
			step_r <= 1'b0;
		end else begin
			case (state_r)
				NCC_H_IDLE: begin
					if (issue) begin
						state_r <= NCC_H_WAIT;
					end
				end
				NCC_H_WAIT: begin
					if (bus.ack) begin
						state_r <= clean_r ? NCC_H_CLR : NCC_H_IDLE;
						step_r <= 1'b0;
					end
				end
				NCC_H_CLR: begin
					state_r <= NCC_H_CWAIT;
				end
				NCC_H_CWAIT: begin
					if (bus.ack) begin
						state_r <= step_r ? NCC_H_IDLE : NCC_H_CLR;
						step_r <= ~step_r;
					end
				end
				default: begin
					state_r <= NCC_H_IDLE;
				end
			endcase
		end
	end

	// clear both remote byte counts after abort
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			addr_r <= 4'h0;
			wdata_r <= 8'h00;
			rd_r <= 1'b0;
			wr_r <= 1'b0;
		end else begin
			rd_r <= issue & ~REQ_WRITE_IN;
			wr_r <= issue & REQ_WRITE_IN | (state_r == NCC_H_CLR);
			if (issue) begin
				addr_r <= REQ_ADDR_IN;
				wdata_r <= eff_data;
			end else if (state_r == NCC_H_CLR) begin
				addr_r <= step_r ? RBC1_OFS : RBC0_OFS;
				wdata_r <= 8'h00;
			end
		end
	end

	// one data port access after an aborted dma
	wire clean_end = (state_r == NCC_H_CWAIT) & bus.ack & step_r;
	wire plain_end = (state_r == NCC_H_WAIT) & bus.ack & ~clean_r;
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			dport_rd_r <= 1'b0;
			dport_wr_r <= 1'b0;
			resp_r <= 1'b0;
			resp_data_r <= 8'h00;
			refused_r <= 1'b0;
		end else begin
			dport_rd_r <= clean_end & ((clean_kind_r == RD_READ) | (clean_kind_r == RD_SEND));
			dport_wr_r <= clean_end & (clean_kind_r == RD_WRITE);
			resp_r <= (take & refuse) | plain_end | clean_end;
			refused_r <= take & refuse;
			if (plain_end) begin
				resp_data_r <= bus.rdata;
			end else if ((take & refuse) | clean_end) begin
				resp_data_r <= 8'h00;
			end
		end
	end

	// shadows; a new start written with a done pulse wins
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			page_sh_r <= PAGE_RST;
			rdma_sh_r <= RD_NONE;
			txprog_r <= 3'h0;
			clean_r <= 1'b0;
			clean_kind_r <= RD_NONE;
		end else begin
			if (issue & is_cmd) begin
				page_sh_r <= eff_ps;
				// a done pulse under a non-start command write must not be lost
				rdma_sh_r <= eff_abort ? RD_NONE : eff_start ? eff_rd :
					RDMA_DONE_IN ? RD_NONE : rdma_sh_r;
				txprog_r <= u_tx ? 3'h0 : txprog_r;
				clean_r <= eff_abort & dma_on;
				clean_kind_r <= rdma_sh_r;
			end else begin
				if (RDMA_DONE_IN) begin
					rdma_sh_r <= RD_NONE;
				end
				if (issue) begin
					txprog_r <= txprog_r | prog_hit;
				end
			end
			if (clean_end) begin
				clean_r <= 1'b0;
			end
		end
	end

	assign bus.addr = addr_r;
	assign bus.wdata = wdata_r;
	assign bus.rd = rd_r;
	assign bus.wr = wr_r;
	assign bus.dport_rd = dport_rd_r;
	assign bus.dport_wr = dport_wr_r;
	assign REQ_READY_OUT = (state_r == NCC_H_IDLE);
	assign RESP_VALID_OUT = resp_r;
	assign RESP_DATA_OUT = resp_data_r;
	assign RESP_REFUSED_OUT = refused_r;
endmodule : ncc_host_end

// >>> ncc_cmd_chk.sv
// assertions on the register port between host end and device end
// assumes one clock and a synchronous active-low reset shared by both ends
`timescale 1ns/1ps
module ncc_cmd_chk
	import ncc_pkg::*;
(
	input wire logic CLK_IN,
	input wire logic RST_B_IN,
	input wire logic [3:0] addr_in,
	input wire logic [7:0] wdata_in,
	input wire logic [7:0] rdata_in,
	input wire logic rd_in,
	input wire logic wr_in,
	input wire logic ack_in,
	input wire logic dport_rd_in,
	input wire logic dport_wr_in
);
	// short local names keep the properties readable
	wire [3:0] addr = addr_in;
	wire [7:0] wdata = wdata_in;
	wire [7:0] rdata = rdata_in;
	wire rd = rd_in;
	wire wr = wr_in;
	wire ack = ack_in;
	wire dport_rd = dport_rd_in;
	wire dport_wr = dport_wr_in;
	logic halt_r;
	logic run_r;
	logic [1:0] page_r;
	logic [3:0] ab_r;
	wire cmd_wr = wr && (addr == CMD_OFS);
	wire abort_wr = cmd_wr && wdata[RD_HI];
	wire ab_run = (ab_r != 4'h0) && (ab_r != 4'hF);
	wire [3:0] ab_nxt = abort_wr ? 4'h1 : (ab_run ? ab_r + 4'h1 : ab_r);
	// halt write keeps run set when it was set
	wire run_nxt = wdata[RUN_B] | (run_r & wdata[HALT_B]);
	always_ff @(posedge CLK_IN) begin
		if (!RST_B_IN) begin
			halt_r <= HALT_RST;
			run_r <= RUN_RST;
			page_r <= PAGE_RST;
			ab_r <= 4'h0;
		end else begin
			halt_r <= cmd_wr ? wdata[HALT_B] : halt_r;
			run_r <= cmd_wr ? run_nxt : run_r;
			page_r <= cmd_wr ? wdata[PS_HI:PS_LO] : page_r;
			ab_r <= ab_nxt;
		end
	end
	default clocking @(posedge CLK_IN);
	endclocking
	default disable iff (!RST_B_IN);
	ack_follows_a: assert property ((rd || wr) |=> ack)
		else $error("ack missing after strobe");
	ack_cause_a: assert property (ack |-> $past(rd || wr))
		else $error("ack without strobe");
	strobe_gap_a: assert property ((rd || wr) |=> !(rd || wr))
		else $error("strobes back to back");
	halt_read_a: assert property ((rd && addr == CMD_OFS) |=> rdata[HALT_B] == halt_r)
		else $error("halt readback wrong");
	run_read_a: assert property ((rd && addr == CMD_OFS) |=> rdata[RUN_B] == run_r)
		else $error("run readback wrong");
	page_read_a: assert property ((rd && addr == CMD_OFS) |=> rdata[PS_HI:PS_LO] == page_r)
		else $error("page readback wrong");
	rsvd_page_a: assert property ((rd && addr != CMD_OFS && page_r == PAGE_RSVD) |=>
		rdata == 8'h00)
		else $error("reserved page read not zero");
	rdata_hold_a: assert property (!$past(rd) |-> $stable(rdata))
		else $error("read data moved");
	dport_win_a: assert property ((dport_rd || dport_wr) |-> ab_r inside {[4'h1:4'hA]})
		else $error("data port touch outside abort");
	dport_excl_a: assert property (!(dport_rd && dport_wr))
		else $error("data port read and write together");
	abort_c: cover property (abort_wr);
	dport_c: cover property (dport_rd);
	rsvd_c: cover property (rd && addr != CMD_OFS && page_r == PAGE_RSVD);
endmodule : ncc_cmd_chk

// >>> nic_command_control_test.sv
// self-checking bench: host end and device end joined by the register port
// assumes engine status inputs are driven here; receive stays idle
`timescale 1ns/1ps
module nic_command_control_test
	import ncc_pkg::*;
;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic valid = 1'b0;
	logic wrt = 1'b0;
	logic [3:0] addr = 4'h0;
	logic [7:0] data = 8'h00;
	logic tx_busy = 1'b0;
	logic tx_done = 1'b0;
	logic rdma_done = 1'b0;
	logic rbc_loaded = 1'b0;
	logic ready, resp_v, resp_ref, accept_new, core_off, tx_start, rdma_start, rdma_abort;
	logic rdma_cmpl, reset_done, got_ref;
	logic [7:0] resp_d;
	logic [7:0] got;
	logic [1:0] ext_page;
	logic ext_rd, ext_wr, dp_out;
	logic [3:0] ext_addr;
	logic [7:0] ext_wdata;
	logic [2:0] rdma_cmd;
	int n_er = 0;
	int bad_count = 0;
	int checks = 0;
	int n_tx = 0;
	int n_rs = 0;
	int n_ab = 0;
	int n_cm = 0;
	int n_dp = 0;
	int n_clr = 0;
	int cm0;
	ncc_bus_if bif ();
	ncc_host_end ncc_host_end_inst (.bus(bif), .CLK_IN(clk), .RST_B_IN(rst_b),
		.REQ_VALID_IN(valid), .REQ_WRITE_IN(wrt), .REQ_ADDR_IN(addr), .REQ_DATA_IN(data),
		.RDMA_DONE_IN(rdma_done), .REQ_READY_OUT(ready), .RESP_VALID_OUT(resp_v),
		.RESP_DATA_OUT(resp_d), .RESP_REFUSED_OUT(resp_ref));
	ncc_dev_end ncc_dev_end_inst (.bus(bif), .CLK_IN(clk), .RST_B_IN(rst_b),
		.TX_BUSY_IN(tx_busy), .TX_DONE_IN(tx_done), .RX_BUSY_IN(1'b0),
		.RDMA_DONE_IN(rdma_done), .RBC_LOADED_IN(rbc_loaded), .EXT_RDATA_IN(8'h5A),
		.EXT_RD_OUT(ext_rd), .EXT_WR_OUT(ext_wr), .EXT_PAGE_OUT(ext_page),
		.EXT_ADDR_OUT(ext_addr), .EXT_WDATA_OUT(ext_wdata), .ACCEPT_NEW_OUT(accept_new),
		.CORE_OFF_OUT(core_off), .TX_START_OUT(tx_start), .RDMA_START_OUT(rdma_start),
		.RDMA_CMD_OUT(rdma_cmd), .RDMA_ABORT_OUT(rdma_abort), .RDMA_CMPL_OUT(rdma_cmpl),
		.RESET_DONE_OUT(reset_done), .DPORT_RD_OUT(dp_out), .DPORT_WR_OUT());
	ncc_cmd_chk ncc_cmd_chk_inst (.CLK_IN(clk), .RST_B_IN(rst_b), .addr_in(bif.addr),
		.wdata_in(bif.wdata), .rdata_in(bif.rdata), .rd_in(bif.rd), .wr_in(bif.wr),
		.ack_in(bif.ack), .dport_rd_in(bif.dport_rd), .dport_wr_in(bif.dport_wr));
	initial begin
		forever #10 clk = ~clk;
	end
	always @(posedge clk) begin
		n_tx += int'(tx_start === 1'b1);
		n_rs += int'(rdma_start === 1'b1);
		n_ab += int'(rdma_abort === 1'b1);
		n_cm += int'(rdma_cmpl === 1'b1);
		n_dp += int'(dp_out === 1'b1);
		n_clr += int'(ext_wr === 1'b1 && ext_wdata === 8'h00 && ext_addr[3:1] === 3'h5);
		n_er += int'(ext_rd === 1'b1);
	end
	task automatic cmp8(input string nm, input logic [7:0] e, input logic [7:0] g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask : cmp8
	task automatic cmp1(input string nm, input logic e, input logic g);
		checks++;
		if (g !== e) begin
			bad_count++;
			$display("mismatch %s exp %b got %b", nm, e, g);
		end
	endtask : cmp1
	// called just after a rising edge; returns at the response edge
	task automatic req(input logic w, input logic [3:0] a, input logic [7:0] d);
		int n;
		n = 0;
		valid <= 1'b1;
		wrt <= w;
		addr <= a;
		data <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ready !== 1'b1 && n < 40);
		valid <= 1'b0;
		do begin
			@(posedge clk);
			n++;
		end while (resp_v !== 1'b1 && n < 40);
		cmp1("response", 1'b1, resp_v);
		got = resp_d;
		got_ref = resp_ref;
	endtask : req
	task automatic rc(input string nm, input logic [7:0] e);
		req(1'b0, CMD_OFS, 8'h00);
		cmp8(nm, e, got);
	endtask : rc
	task automatic wc(input logic [7:0] d, input logic r);
		req(1'b1, CMD_OFS, d);
		cmp1("refused", r, got_ref);
	endtask : wc
	task automatic pulse(input bit dma);
		if (dma) begin
			rdma_done <= 1'b1;
		end else begin
			tx_done <= 1'b1;
		end
		@(posedge clk);
		tx_done <= 1'b0;
		rdma_done <= 1'b0;
		@(posedge clk);
	endtask : pulse
	task automatic results();
		$display("checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : results
	initial begin
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		rc("cmd reset", 8'h21);
		cmp1("reset done", 1'b1, reset_done);
		cmp1("core off", 1'b1, core_off);
		wc(8'h22, 1'b0);
		rc("cmd run", 8'h22);
		cmp1("accept", 1'b1, accept_new);
		cmp1("reset done clr", 1'b0, reset_done);
		$display("test start ends");
		for (int p = 0; p < 4; p++) begin
			wc({p[1:0], 6'h02}, 1'b0);
			rc("cmd page", {p[1:0], 6'h22});
			cmp8("page out", {6'h00, p[1:0]}, {6'h00, ext_page});
			req(1'b0, 4'h1, 8'h00);
			cmp8("page data", (p == 3) ? 8'h00 : 8'h5A, got);
		end
		cmp8("page reads", 8'h03, 8'(n_er));
		wc(8'h02, 1'b0);
		$display("test page ends");
		wc(8'h06, 1'b1);
		req(1'b1, TPSR_OFS, 8'h40);
		req(1'b1, TBC0_OFS, 8'h3C);
		req(1'b1, TBC1_OFS, 8'h00);
		tx_busy <= 1'b1;
		wc(8'h06, 1'b0);
		rc("cmd tx", 8'h26);
		wc(8'h02, 1'b0);
		rc("cmd tx hold", 8'h26);
		pulse(1'b0);
		rc("cmd tx clr", 8'h22);
		cmp8("tx starts", 8'h01, 8'(n_tx));
		wc(8'h06, 1'b1);
		$display("test tx ends");
		rbc_loaded <= 1'b1;
		for (int c = 1; c < 4; c++) begin
			wc({2'h0, c[2:0], 3'h2}, 1'b0);
			rc("cmd dma", {2'h0, c[2:0], 3'h2});
			cmp8("dma out", {5'h00, c[2:0]}, {5'h00, rdma_cmd});
			pulse(1'b1);
			rc("cmd dma done", 8'h22);
		end
		cmp8("dma starts", 8'h03, 8'(n_rs));
		wc(8'h0A, 1'b0);
		wc(8'h12, 1'b1);
		wc(8'h22, 1'b0);
		rc("cmd abort", 8'h22);
		cmp8("aborts", 8'h01, 8'(n_ab));
		cmp8("dport reads", 8'h01, 8'(n_dp));
		cmp8("count clears", 8'h02, 8'(n_clr));
		rbc_loaded <= 1'b0;
		cm0 = n_cm;
		wc(8'h0A, 1'b0);
		rc("cmd reissue", 8'h22);
		cmp8("completes", 8'(cm0 + 1), 8'(n_cm));
		rbc_loaded <= 1'b1;
		wc(8'h0A, 1'b0);
		rbc_loaded <= 1'b0;
		req(1'b1, TPSR_OFS, 8'h40);
		req(1'b1, TBC0_OFS, 8'h3C);
		req(1'b1, TBC1_OFS, 8'h00);
		wc(8'h06, 1'b0);
		rc("cmd tx over dma", 8'h26);
		cmp8("tx starts again", 8'h02, 8'(n_tx));
		pulse(1'b0);
		$display("test dma ends");
		wc(8'h01, 1'b0);
		rc("cmd halt", 8'h23);
		cmp1("drain on", 1'b0, core_off);
		cmp1("drain accept", 1'b0, accept_new);
		tx_busy <= 1'b0;
		repeat (3) @(posedge clk);
		cmp1("core off", 1'b1, core_off);
		cmp1("reset done set", 1'b1, reset_done);
		wc(8'h02, 1'b0);
		cmp1("restart", 1'b1, accept_new);
		$display("test halt ends");
		results();
	end
	// the whole sequence needs well under a thousand cycles
	initial begin
		repeat (5000) @(posedge clk);
		bad_count++;
		$display("mismatch watchdog exp done got timeout");
		results();
	end
endmodule : nic_command_control_test
